//--- hw/brd_pkg.sv
// Constants, divisor table and carrier types of the baud rate divider.
package brd_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int BRD_SEL_W = 5;
  localparam int BRD_DIV_W = 20;
  localparam int BRD_ROM_W = 19;
  localparam int BRD_ROM_DEPTH = 32;
  localparam logic [19:0] BRD_MIN_DIV = 20'h00006;
  localparam logic [19:0] BRD_MAX_DIV = 20'h80001;
  localparam int BRD_WIDE_BIT = 4;
  localparam logic [4:0] BRD_SEL_RST = 5'h1f;
  localparam logic [1:0] BRD_QTR_RST = 2'h0;
  localparam logic [1:0] BRD_QTR_STEP = 2'h1;
  localparam logic [19:0] BRD_ONE = 20'h00001;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BRD_CLK_MHZ = 50;
  localparam int BRD_CHANGE_NS = 3500;
  localparam int BRD_CHANGE_CYC = BRD_CHANGE_NS * BRD_CLK_MHZ / 1000;

  // ----------------------------------------------------------------
  // Divisor table: 32X codes first, then 16X codes
  // ----------------------------------------------------------------
  localparam logic [18:0] BRD_DIV_ROM [BRD_ROM_DEPTH] = '{
    19'h00c60, 19'h00840, 19'h005a0, 19'h00499,
    19'h00420, 19'h00318, 19'h00210, 19'h00108,
    19'h00084, 19'h00058, 19'h00042, 19'h0002c,
    19'h00021, 19'h00016, 19'h00010, 19'h00008,
    19'h018c0, 19'h01080, 19'h00b40, 19'h00933,
    19'h00840, 19'h00420, 19'h00210, 19'h00108,
    19'h000b0, 19'h0009e, 19'h00084, 19'h00058,
    19'h00042, 19'h0002c, 19'h00021, 19'h00010
  };

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] code;
    logic [4:0] conn;
    logic strobe;
  } brd_sel_req_t;

  typedef enum logic [1:0] {
    BRD_ST_HIGH = 2'b01,
    BRD_ST_LOW = 2'b10
  } brd_phase_t;

endpackage : brd_pkg

//--- hw/brd_sel_latch.sv
// Divisor select latch with pull-up behaviour on open inputs.
module brd_sel_latch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Select inputs
  input brd_pkg::brd_sel_req_t req,
  // Latched select
  output logic [4:0] sel_ff
);
  import brd_pkg::*;

  logic [4:0] sel_eff;
  logic [4:0] nxt_sel;

  // ----------------------------------------------------------------
  // Input levels and latch
  // ----------------------------------------------------------------
  always_comb begin
    sel_eff = (req.code & req.conn) | ~req.conn;
    nxt_sel = sel_ff;
    if (req.strobe) begin
      nxt_sel = sel_eff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_ff <= BRD_SEL_RST;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

endmodule : brd_sel_latch

//--- hw/brd_qtr_div.sv
// Fixed divide-by-four reference output.
module brd_qtr_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Output
  output logic qtr_ff
);
  import brd_pkg::*;

  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic nxt_qtr;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff + BRD_QTR_STEP;
    nxt_qtr = nxt_cnt[1];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= BRD_QTR_RST;
      qtr_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      qtr_ff <= nxt_qtr;
    end
  end

endmodule : brd_qtr_div

//--- hw/brd_top.sv
// Baud rate divider: select latch, divisor table and output divider.
//
// What this block does
// - Divide the reference clock by a divisor taken from the table, clamped to six through 2^19+1.
// - Even divisor gives square output; odd divisor high one period longer.
// - A fixed output runs at one quarter of the reference clock.
// - Four-bit variant indexes a sixteen-entry table of nineteen-bit divisors.
// - Select latch loads the inputs on each clock edge while the strobe input is high.
// - Default build: new divisor takes effect within 3.5 us, once latched while the strobe is high.
// - Build option delays a new divisor to the end of the half-cycle.
// - Open select inputs read as one; the strobe has no pull-up.
// - Five-bit 32X codes select 3168 down to 8 in table order.
// - Five-bit 16X codes select 6336 down to 16 in table order.
module brd_top #(
  parameter bit WIDE_SEL = 1'b0,
  parameter bit DEFER_CHANGE = 1'b0
) (
  // Reference clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divisor select
  input wire logic [4:0] div_sel,
  input wire logic [4:0] div_sel_conn,
  input wire logic div_sel_strobe,
  // Clock outputs
  output logic baud_clk,
  output logic ref_quarter,
  // Status
  output logic [4:0] div_sel_latched,
  output logic [19:0] div_active
);
  import brd_pkg::*;

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  function automatic logic [19:0] brd_lookup(input logic [4:0] code,
                                             input logic wide);
    logic [4:0] idx;
    logic [19:0] d;
    idx = code;
    if (!wide) begin
      idx = {1'b1, code[3:0]};
    end
    d = {1'b0, BRD_DIV_ROM[idx]};
    if (d < BRD_MIN_DIV) begin
      d = BRD_MIN_DIV;
    end else if (d > BRD_MAX_DIV) begin
      d = BRD_MAX_DIV;
    end
    return d;
  endfunction : brd_lookup

  function automatic logic [19:0] brd_half(input logic [19:0] d,
                                           input logic high);
    logic [20:0] sum;
    sum = {1'b0, d} + {20'h00000, high};
    return sum[20:1] - BRD_ONE;
  endfunction : brd_half

  // ----------------------------------------------------------------
  // Select latch and quarter output
  // ----------------------------------------------------------------
  brd_sel_req_t sel_req;
  logic [4:0] sel_ff;
  logic qtr_ff;

  assign sel_req.code = div_sel;
  assign sel_req.conn = div_sel_conn;
  assign sel_req.strobe = div_sel_strobe;

  brd_sel_latch u_latch (
    .clk(clk),
    .rst(rst),
    .req(sel_req),
    .sel_ff(sel_ff)
  );

  brd_qtr_div u_qtr (
    .clk(clk),
    .rst(rst),
    .qtr_ff(qtr_ff)
  );

  // ----------------------------------------------------------------
  // Output divider
  // ----------------------------------------------------------------
  brd_phase_t phase_ff;
  brd_phase_t nxt_phase;
  logic [19:0] cnt_ff;
  logic [19:0] nxt_cnt;
  logic [19:0] div_ff;
  logic [19:0] nxt_div;
  logic [19:0] div_new;
  logic out_ff;
  logic nxt_out;
  logic started_ff;
  logic nxt_started;

  assign div_new = brd_lookup(sel_ff, WIDE_SEL);

  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    nxt_out = out_ff;
    nxt_started = 1'b1;
    if (!started_ff) begin
      nxt_div = div_new;
      nxt_phase = BRD_ST_HIGH;
      nxt_out = 1'b1;
      nxt_cnt = brd_half(div_new, 1'b1);
    end else if (!DEFER_CHANGE && div_new != div_ff) begin
      nxt_div = div_new;
      nxt_phase = BRD_ST_HIGH;
      nxt_out = 1'b1;
      nxt_cnt = brd_half(div_new, 1'b1);
    end else if (cnt_ff != 20'h00000) begin
      nxt_cnt = cnt_ff - BRD_ONE;
    end else begin
      // take new divisor at half end
      nxt_div = div_new;
      case (phase_ff)
        BRD_ST_HIGH: begin
          nxt_phase = BRD_ST_LOW;
          nxt_out = 1'b0;
          nxt_cnt = brd_half(div_new, 1'b0);
        end
        BRD_ST_LOW: begin
          nxt_phase = BRD_ST_HIGH;
          nxt_out = 1'b1;
          nxt_cnt = brd_half(div_new, 1'b1);
        end
        default: begin
          nxt_phase = BRD_ST_HIGH;
          nxt_out = 1'b1;
          nxt_cnt = brd_half(div_new, 1'b1);
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= BRD_ST_HIGH;
      cnt_ff <= 20'h00000;
      div_ff <= BRD_MIN_DIV;
      out_ff <= 1'b0;
      started_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
      out_ff <= nxt_out;
      started_ff <= nxt_started;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign baud_clk = out_ff;
  assign ref_quarter = qtr_ff;
  assign div_sel_latched = sel_ff;
  assign div_active = div_ff;

endmodule : brd_top

//--- sim/brd_top_sva.sv
// Port assertions of the baud rate divider.
module brd_chk import brd_pkg::*; #(
  parameter bit WIDE_SEL = 1'b0,
  parameter bit DEFER_CHANGE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Select inputs
  input wire logic [4:0] div_sel,
  input wire logic [4:0] div_sel_conn,
  input wire logic div_sel_strobe,
  // Outputs
  input wire logic baud_clk,
  input wire logic ref_quarter,
  input wire logic [4:0] div_sel_latched,
  input wire logic [19:0] div_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_ff;
  logic up;
  assign up = age_ff == 2'h3;
  always_ff @(posedge clk) age_ff <= rst ? 2'h0 : age_ff + {1'b0, !up};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_QTR:
    assert property (up |-> ref_quarter == !$past(ref_quarter, 2))
    else $error("quarter pattern");
  AST_QTR_RUN:
    assert property ($rose(ref_quarter) |=> ref_quarter ##1 !ref_quarter)
    else $error("quarter high time");
  AST_PASS:
    assert property (div_sel_strobe |=> div_sel_latched ==
      ($past(div_sel) | ~$past(div_sel_conn)))
    else $error("latch pass");
  AST_PULLUP:
    assert property (div_sel_strobe && div_sel_conn == 5'h00 |=>
      div_sel_latched == 5'h1f)
    else $error("pull-up");
  AST_HOLD:
    assert property (!div_sel_strobe |=> $stable(div_sel_latched))
    else $error("latch hold");
  AST_RANGE:
    assert property (div_active >= BRD_MIN_DIV && div_active <= BRD_MAX_DIV)
    else $error("divisor range");
  AST_LOOKUP:
    assert property (up && !DEFER_CHANGE |-> div_active == {1'b0,
      BRD_DIV_ROM[WIDE_SEL ? $past(div_sel_latched) :
      {1'b1, $past(div_sel_latched[3:0])}]})
    else $error("table lookup");
  AST_RESTART:
    assert property (up && !DEFER_CHANGE && $changed(div_active) |->
      baud_clk)
    else $error("restart");
  AST_DEFER:
    assert property (up && DEFER_CHANGE && $changed(div_active) |->
      $changed(baud_clk))
    else $error("deferred change off a half-cycle end");
endmodule : brd_chk

bind brd_top brd_chk #(.WIDE_SEL(WIDE_SEL), .DEFER_CHANGE(DEFER_CHANGE))
  u_chk (.clk(clk), .rst(rst), .div_sel(div_sel),
  .div_sel_conn(div_sel_conn), .div_sel_strobe(div_sel_strobe),
  .baud_clk(baud_clk), .ref_quarter(ref_quarter),
  .div_sel_latched(div_sel_latched), .div_active(div_active));

//--- sim/brd_uart_sink.sv
// Baud clock consumer that measures each high and low half in cycles.
module brd_uart_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Baud clock in, half lengths out
  input wire logic baud_clk,
  output logic [19:0] hi_len,
  output logic [19:0] lo_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_ff;
  logic [19:0] run_ff;
  always_ff @(posedge clk) begin
    prev_ff <= baud_clk;
    run_ff <= (rst || baud_clk != prev_ff) ? 20'h1 : run_ff + 20'h1;
    if (rst) begin
      hi_len <= 20'h0;
      lo_len <= 20'h0;
    end else if (baud_clk != prev_ff) begin
      if (prev_ff)
        hi_len <= run_ff;
      else
        lo_len <= run_ff;
    end
  end
endmodule : brd_uart_sink

//--- sim/tb.sv
// Self-checking bench for the baud rate divider.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TBL [32] = '{3168, 2112, 1440, 1177, 1056, 792, 528, 264,
    132, 88, 66, 44, 33, 22, 16, 8, 6336, 4224, 2880, 2355, 2112, 1056, 528,
    264, 176, 158, 132, 88, 66, 44, 33, 16};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic div_sel_strobe = 1'b1;
  logic [4:0] div_sel = 5'h00;
  logic [4:0] div_sel_conn = 5'h1f;
  logic [4:0] exp_sel = 5'h1f;
  logic [4:0] div_sel_latched;
  logic [10:0] r;
  logic baud_clk;
  logic [19:0] div_active;
  logic [19:0] hi_len;
  logic [19:0] lo_len;
  logic baud_clk2;
  logic b;
  logic [19:0] div_active2;
  logic [19:0] hi_len2;
  logic [19:0] lo_len2;
  int errors = 0;
  int n_compared = 0;
  int seed = 32'h53ae;
  int d;

  brd_top #(.WIDE_SEL(1'b1)) DUT (.clk(clk), .rst(rst), .div_sel(div_sel),
    .div_sel_conn(div_sel_conn), .div_sel_strobe(div_sel_strobe),
    .baud_clk(baud_clk), .ref_quarter(),
    .div_sel_latched(div_sel_latched), .div_active(div_active));
  brd_uart_sink u_sink (.clk(clk), .rst(rst), .baud_clk(baud_clk),
    .hi_len(hi_len), .lo_len(lo_len));
  brd_top #(.WIDE_SEL(1'b0), .DEFER_CHANGE(1'b1)) DUT2 (.clk(clk),
    .rst(rst), .div_sel(div_sel), .div_sel_conn(div_sel_conn),
    .div_sel_strobe(div_sel_strobe), .baud_clk(baud_clk2), .ref_quarter(),
    .div_sel_latched(), .div_active(div_active2));
  brd_uart_sink u_sink2 (.clk(clk), .rst(rst), .baud_clk(baud_clk2),
    .hi_len(hi_len2), .lo_len(lo_len2));

  initial forever #10 clk = ~clk;

  function automatic logic [19:0] exp_div(input logic [4:0] c);
    return 20'(TBL[c]);
  endfunction : exp_div

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    step(10);
    rst = 1'b0;
    for (int c = 0; c < 32; c++) begin
      div_sel = 5'(c);
      d = TBL[c];
      step(3);
      chk(div_active, exp_div(5'(c)));
      if (d <= 1200) begin
        step(3 * d);
        chk(hi_len, 20'((d + 1) / 2));
        chk(lo_len, 20'(d / 2));
      end
    end
    $display("table test done");
    for (int i = 0; i < 40; i++) begin
      r = 11'($random(seed));
      if (i < 3)
        r = {1'b1, r[9:5], 5'h00};
      {div_sel_strobe, div_sel, div_sel_conn} = r;
      if (r[10])
        exp_sel = r[9:5] | ~r[4:0];
      step(3);
      chk({15'h0, div_sel_latched}, {15'h0, exp_sel});
      chk(div_active, exp_div(exp_sel));
    end
    $display("random select test done");
    rst = 1'b1;
    {div_sel_strobe, div_sel, div_sel_conn} = {1'b1, 5'h0f, 5'h1f};
    step(2);
    chk({19'h0, baud_clk}, 20'h00000);
    chk(div_active, 20'h00006);
    chk({15'h0, div_sel_latched}, 20'h0001f);
    rst = 1'b0;
    step(1);
    chk({19'h0, baud_clk}, 20'h00001);
    chk(div_active, exp_div(5'h1f));
    chk(div_active2, exp_div({1'b1, 4'hf}));
    b = baud_clk2;
    for (int i = 0; i < 20 && baud_clk2 == b; i++)
      step(1);
    chk({19'h0, baud_clk2 != b}, 20'h00001);
    div_sel = 5'h0e;
    step(3);
    chk(div_active, exp_div(5'h0e));
    chk(div_active2, exp_div({1'b1, 4'hf}));
    step(6);
    chk(div_active2, exp_div({1'b1, 4'he}));
    step(99);
    chk(hi_len2, 20'h00011);
    chk(lo_len2, 20'h00010);
    $display("reset and deferred change test done");
    tally_and_finish();
  end

  initial begin
    step(60000);
    errors++;
    tally_and_finish();
  end
endmodule : tb
